// >>> hdl/adc_ctrl_pkg.sv
// Purpose: Shared constants for the converter control block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Offsets are word indices; the byte address is four times the index

package adc_ctrl_pkg;

	// Register word indices; the bus sees each one at four times its index
	localparam logic [11:0] OFF_CTRL = 12'hF70;
	localparam logic [11:0] OFF_PRESCALE = 12'hF71;
	localparam logic [11:0] OFF_RESULT_HIGH = 12'hF72;
	localparam logic [11:0] OFF_RESULT_LOW = 12'hF73;
	localparam logic [11:0] OFF_SAMPLE = 12'hF74;
	localparam logic [11:0] OFF_SETTLE = 12'hF75;
	localparam logic [11:0] OFF_IRQ_STATUS = 12'hF76;
	localparam logic [11:0] OFF_IRQ_MASK = 12'hF77;

	// Control register field positions
	localparam int CTRL_START_BIT = 7;
	localparam int CTRL_REF_BIT = 5;
	localparam int CTRL_EN_BIT = 4;
	localparam int CTRL_CH_LSB = 0;

	// Reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] PRESCALE_RESET = 8'h01;
	localparam logic [7:0] SAMPLE_RESET = 8'h32;
	localparam logic [7:0] SETTLE_RESET = 8'h19;

	// Timing
	localparam int CLK_MHZ = 50;
	localparam int SAMPLE_MIN_NS = 1000;
	localparam int SETTLE_MIN_NS = 500;
	localparam int SAMPLE_MIN_CYC = (SAMPLE_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int SETTLE_MIN_CYC = (SETTLE_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0] CONV_CYCLES = 4'hD;

	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SAMPLE = 2'b01,
		ST_SETTLE = 2'b10,
		ST_CONVERT = 2'b11
	} seq_state_t;

endpackage : adc_ctrl_pkg

// >>> hdl/adc_saturate.sv
// Purpose: Clamp the analog core's raw code to a 10-bit result
// Assumes: Core reports under and over range flags
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none

module adc_saturate (
	input wire logic [9:0] raw_code,
	input wire logic under_range,
	input wire logic over_range,
	output logic [9:0] clamped_code
);

	// Under range pins to zero, over range pins to full scale
	assign clamped_code = under_range ? 10'h000 : (over_range ? 10'h3FF : raw_code);

endmodule : adc_saturate
`default_nettype wire

// >>> hdl/adc_conversion_ctrl.sv
// Purpose: Sequencer and APB registers around a 10-bit SAR converter
// Assumes: Analog core decides one bit per converter clock
// Notes: Result code is 1024*vin/vref, clamped
`timescale 1ns/1ps
`default_nettype none

module adc_conversion_ctrl (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [13:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic comparator_bit,
	input wire logic under_range,
	input wire logic over_range,
	output logic [7:0] channel_onehot,
	output logic sample_active,
	output logic hold_active,
	output logic [9:0] trial_code,
	output logic reference_buffer,
	output logic converter_power,
	output logic irq
);

	// Software registers
	logic [7:0] ctrl_r;
	logic [7:0] prescale_r;
	logic [7:0] sample_time_count_r;
	logic [7:0] settle_time_count_r;
	logic irq_status_r;
	logic irq_mask_r;
	logic [9:0] result_r;
	logic [1:0] result_low_bits_r;

	// Sequencer state
	adc_ctrl_pkg::seq_state_t state_r;
	adc_ctrl_pkg::seq_state_t state_nxt;
	logic [7:0] phase_cnt_r;
	logic [7:0] div_cnt_r;
	logic [3:0] bit_cnt_r;
	logic [9:0] sar_r;

	// Match a byte address against a register's word index; unaligned never hits
	function automatic logic reg_hit(input logic [13:0] addr, input logic [11:0] index);
		reg_hit = addr == {index, 2'b00};
	endfunction : reg_hit

	// Bus decode
	wire logic acc = psel & penable;
	wire logic wr = acc & pwrite;
	wire logic rd = acc & ~pwrite;
	wire logic hit_ctrl = reg_hit(paddr, adc_ctrl_pkg::OFF_CTRL);
	wire logic hit_pre = reg_hit(paddr, adc_ctrl_pkg::OFF_PRESCALE);
	wire logic hit_high = reg_hit(paddr, adc_ctrl_pkg::OFF_RESULT_HIGH);
	wire logic hit_low = reg_hit(paddr, adc_ctrl_pkg::OFF_RESULT_LOW);
	wire logic hit_smp = reg_hit(paddr, adc_ctrl_pkg::OFF_SAMPLE);
	wire logic hit_set = reg_hit(paddr, adc_ctrl_pkg::OFF_SETTLE);
	wire logic hit_sts = reg_hit(paddr, adc_ctrl_pkg::OFF_IRQ_STATUS);
	wire logic hit_msk = reg_hit(paddr, adc_ctrl_pkg::OFF_IRQ_MASK);
	wire logic hit_any = hit_ctrl | hit_pre | hit_high | hit_low | hit_smp | hit_set | hit_sts | hit_msk;

	// Start request only from a one written to the start bit
	wire logic start_req = wr & hit_ctrl & pwdata[adc_ctrl_pkg::CTRL_START_BIT];
	wire logic enabled = ctrl_r[adc_ctrl_pkg::CTRL_EN_BIT];
	// Enable as it stands after this cycle's write, so start and disable act at once
	wire logic enable_nxt = (wr & hit_ctrl) ? pwdata[adc_ctrl_pkg::CTRL_EN_BIT] : enabled;
	wire logic [2:0] input_channel_select = ctrl_r[2:0];

	// Converter clock tick: system clock divided by prescaler
	wire logic [7:0] div_eff = (prescale_r == 8'h00) ? 8'h01 : prescale_r;
	wire logic conversion_clock = div_cnt_r == 8'(div_eff - 8'h01);

	// Phase lengths, never shorter than the minimum times
	wire logic [7:0] smp_len = (sample_time_count_r < 8'(adc_ctrl_pkg::SAMPLE_MIN_CYC))
		? 8'(adc_ctrl_pkg::SAMPLE_MIN_CYC) : sample_time_count_r;
	wire logic [7:0] set_len = (settle_time_count_r < 8'(adc_ctrl_pkg::SETTLE_MIN_CYC))
		? 8'(adc_ctrl_pkg::SETTLE_MIN_CYC) : settle_time_count_r;

	// Last converter clock of the 13-clock conversion
	wire logic conv_done = (state_r == adc_ctrl_pkg::ST_CONVERT) & conversion_clock
		& (bit_cnt_r == 4'(adc_ctrl_pkg::CONV_CYCLES - 4'h1)) & ~start_req;

	// Saturated final code
	logic [9:0] final_code;
	adc_saturate u_sat (
		.raw_code(sar_r),
		.under_range(under_range),
		.over_range(over_range),
		.clamped_code(final_code)
	);

	// Next state of the sequencer
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			adc_ctrl_pkg::ST_IDLE: begin
				// Waits here for a start write
				state_nxt = adc_ctrl_pkg::ST_IDLE;
			end
			adc_ctrl_pkg::ST_SAMPLE: begin
				// Sampling lasts its clamped length
				if (phase_cnt_r == 8'(smp_len - 8'h01)) begin
					state_nxt = adc_ctrl_pkg::ST_SETTLE;
				end
			end
			adc_ctrl_pkg::ST_SETTLE: begin
				// Settling lasts its clamped length
				if (phase_cnt_r == 8'(set_len - 8'h01)) begin
					state_nxt = adc_ctrl_pkg::ST_CONVERT;
				end
			end
			adc_ctrl_pkg::ST_CONVERT: begin
				// Leaves after the thirteenth converter clock
				if (conv_done) begin
					state_nxt = adc_ctrl_pkg::ST_IDLE;
				end
			end
			default: begin
				// Unused code falls back to idle
				state_nxt = adc_ctrl_pkg::ST_IDLE;
			end
		endcase
		// Any start with enable set restarts from sampling, aborting a running one
		if (start_req & pwdata[adc_ctrl_pkg::CTRL_EN_BIT]) begin
			state_nxt = adc_ctrl_pkg::ST_SAMPLE;
		end
		// Disabled converter halts in the same cycle; pending flag is untouched
		if (~enable_nxt) begin
			state_nxt = adc_ctrl_pkg::ST_IDLE;
		end
	end

	// State and phase counter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= adc_ctrl_pkg::ST_IDLE;
			phase_cnt_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			phase_cnt_r <= (state_nxt != state_r || start_req) ? 8'h00 : 8'(phase_cnt_r + 8'h01);
		end
	end

	// Prescaler runs only in the conversion phase
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_cnt_r <= 8'h00;
		end else if (state_r != adc_ctrl_pkg::ST_CONVERT || conversion_clock || start_req) begin
			div_cnt_r <= 8'h00;
		end else begin
			div_cnt_r <= 8'(div_cnt_r + 8'h01);
		end
	end

	// Successive approximation: one decision per converter clock
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bit_cnt_r <= 4'h0;
			sar_r <= 10'h000;
		end else if (state_r != adc_ctrl_pkg::ST_CONVERT || start_req) begin
			bit_cnt_r <= 4'h0;
			sar_r <= 10'h200;
		end else if (conversion_clock) begin
			bit_cnt_r <= 4'(bit_cnt_r + 4'h1);
			// Ten decisions MSB first, then three finishing clocks
			if (bit_cnt_r < 4'hA) begin
				sar_r <= sar_decide(sar_r, bit_cnt_r, comparator_bit);
			end
		end
	end

	// Keep or drop the trial bit and set the next trial bit
	function automatic logic [9:0] sar_decide(input logic [9:0] cur, input logic [3:0] step, input logic keep);
		logic [9:0] mask;
		mask = 10'h200 >> step;
		sar_decide = keep ? cur : (cur & ~mask);
		if (step < 4'h9) begin
			sar_decide = sar_decide | (mask >> 1);
		end
	endfunction : sar_decide

	// Control register with self-clearing start bit
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_r <= adc_ctrl_pkg::CTRL_RESET;
		end else begin
			if (wr & hit_ctrl) begin
				// Reserved bits 6 and 3 stay zero
				ctrl_r[5:4] <= pwdata[5:4];
				ctrl_r[2:0] <= pwdata[2:0];
			end
			if (start_req & pwdata[adc_ctrl_pkg::CTRL_EN_BIT]) begin
				ctrl_r[adc_ctrl_pkg::CTRL_START_BIT] <= 1'b1;
			end else if (conv_done | ~enable_nxt) begin
				ctrl_r[adc_ctrl_pkg::CTRL_START_BIT] <= 1'b0;
			end
		end
	end

	// Timing registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prescale_r <= adc_ctrl_pkg::PRESCALE_RESET;
			sample_time_count_r <= adc_ctrl_pkg::SAMPLE_RESET;
			settle_time_count_r <= adc_ctrl_pkg::SETTLE_RESET;
			irq_mask_r <= 1'b0;
		end else if (wr) begin
			// Each timing register takes the low byte of its own write, the mask only bit 0
			if (hit_pre) begin
				prescale_r <= pwdata[7:0];
			end
			if (hit_smp) begin
				sample_time_count_r <= pwdata[7:0];
			end
			if (hit_set) begin
				settle_time_count_r <= pwdata[7:0];
			end
			if (hit_msk) begin
				irq_mask_r <= pwdata[0];
			end
		end
	end

	// Result capture and low-bit latch on high byte read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			result_r <= 10'h000;
			result_low_bits_r <= 2'b00;
		end else begin
			if (conv_done) begin
				result_r <= final_code;
			end
			if (rd & hit_high) begin
				result_low_bits_r <= result_r[1:0];
			end
		end
	end

	// Completion flag: set wins over write-one-to-clear, kept on disable
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_status_r <= 1'b0;
		end else if (conv_done) begin
			irq_status_r <= 1'b1;
		end else if (wr & hit_sts & pwdata[0]) begin
			irq_status_r <= 1'b0;
		end
	end

	// Read data mux, registered
	wire logic [7:0] rd_mux = hit_ctrl ? ctrl_r
		: hit_pre ? prescale_r
		: hit_high ? result_r[9:2]
		: hit_low ? {result_low_bits_r, 6'h00}
		: hit_smp ? sample_time_count_r
		: hit_set ? settle_time_count_r
		: hit_sts ? {7'h00, irq_status_r}
		: hit_msk ? {7'h00, irq_mask_r}
		: 8'h00;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (psel & ~penable & ~pwrite) begin
			prdata <= {24'h000000, rd_mux};
		end
	end

	// Zero wait states; unmapped addresses flag an error
	assign pready = 1'b1;
	assign pslverr = acc & ~hit_any;

	// Analog side controls
	assign channel_onehot = enabled ? (8'h01 << input_channel_select) : 8'h00;
	assign sample_active = state_r == adc_ctrl_pkg::ST_SAMPLE;
	assign hold_active = state_r == adc_ctrl_pkg::ST_SETTLE || state_r == adc_ctrl_pkg::ST_CONVERT;
	assign trial_code = sar_r;
	assign reference_buffer = ctrl_r[adc_ctrl_pkg::CTRL_REF_BIT] & enabled;
	assign converter_power = enabled;
	assign irq = irq_status_r & irq_mask_r;

endmodule : adc_conversion_ctrl
`default_nettype wire

// >>> tb/adc_ctrl_properties.sv
// Purpose: Port checks for the converter control block
// Assumes: Zero-wait APB, one clock domain
// Notes: Bound to the top module
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_properties (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [13:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [7:0] channel_onehot,
	input wire logic sample_active,
	input wire logic hold_active,
	input wire logic reference_buffer,
	input wire logic converter_power,
	input wire logic irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Length of the current sampling and hold runs
	logic [11:0] samp_cnt_r;
	logic [11:0] hold_cnt_r;
	// Count consecutive cycles in each phase; wide enough for the longest hold
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			samp_cnt_r <= 12'h000;
			hold_cnt_r <= 12'h000;
		end else begin
			samp_cnt_r <= sample_active ? samp_cnt_r + 12'h001 : 12'h000;
			hold_cnt_r <= hold_active ? hold_cnt_r + 12'h001 : 12'h000;
		end
	end
	pready_high_a: assert property (pready) else $error("pready low");
	slverr_decode_a: assert property (psel && penable |-> pslverr == (paddr[1:0] != 2'b00
		|| paddr[13:2] < 12'hF70 || paddr[13:2] > 12'hF77))
		else $error("pslverr decode wrong");
	phase_excl_a: assert property (!(sample_active && hold_active)) else $error("two phases at once");
	sample_len_a: assert property ($fell(sample_active) && converter_power |-> hold_active && samp_cnt_r >= 12'h032)
		else $error("sampling too short");
	hold_len_a: assert property ($fell(hold_active) && !sample_active && converter_power |-> hold_cnt_r >= 12'h026)
		else $error("hold too short");
	channel_sel_a: assert property (converter_power ? $onehot(channel_onehot) : channel_onehot == 8'h00)
		else $error("channel select wrong");
	ref_gate_a: assert property (reference_buffer |-> converter_power) else $error("buffer on while off");
	power_idle_a: assert property (!converter_power |-> !sample_active && !hold_active)
		else $error("phase while disabled");
	irq_cause_a: assert property ($rose(irq) |-> $past(hold_active) || $past(psel && penable && pwrite))
		else $error("irq without cause");
endmodule : adc_ctrl_properties
bind adc_conversion_ctrl adc_ctrl_properties u_props (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .channel_onehot(channel_onehot),
	.sample_active(sample_active), .hold_active(hold_active), .reference_buffer(reference_buffer),
	.converter_power(converter_power), .irq(irq));
`default_nettype wire

// >>> tb/adc_core_model.sv
// Purpose: Behavioural analog mux and comparator
// Assumes: Levels are signed codes, 12 bits per channel
// Notes: Comparator wanders outside the hold phase
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
	input wire logic clk,
	input wire logic [95:0] levels,
	input wire logic [7:0] channel_onehot,
	input wire logic hold_active,
	input wire logic [9:0] trial_code,
	output logic comparator_bit,
	output logic under_range,
	output logic over_range
);
	logic signed [11:0] sel_level;
	logic toggle_r = 1'b0;
	// Level of the channel the mux has closed
	always_comb begin
		sel_level = 12'h000;
		for (int i = 0; i < 8; i++)
			if (channel_onehot[i]) sel_level = levels[12*i +: 12];
	end
	// Meaningless pattern between decisions
	always @(posedge clk) toggle_r <= ~toggle_r;
	assign comparator_bit = hold_active ? ($signed({2'b00, trial_code}) <= sel_level) : toggle_r;
	assign under_range = sel_level < 12'sh000;
	assign over_range = sel_level > 12'sh3FF;
endmodule : adc_core_model
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: Zero-wait APB slave, behavioural analog core
// Notes: Table rows cover every channel code
`timescale 1ns/1ps
`default_nettype none
module testbench;
	typedef struct {logic [2:0] ch; logic [11:0] lv; logic [9:0] res;} row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [13:0] paddr = 14'h0000;
	logic [31:0] pwdata = 32'h00000000;
	logic [95:0] levels = {8{12'h0F0}};
	logic [31:0] prdata;
	logic pready, pslverr, cmp, under, over, sa, ha, rb, pw, irq, e;
	logic [7:0] onehot;
	logic [7:0] q;
	logic [9:0] trial;
	int failures = 0;
	int samples_checked = 0;
	// Reset values, last one unmapped (error flag in bit 8)
	logic [11:0] reg_a [6] = '{12'hF70, 12'hF71, 12'hF74, 12'hF75, 12'hF77, 12'hF78};
	logic [9:0] reg_v [6] = '{10'h000, 10'h001, 10'h032, 10'h019, 10'h000, 10'h100};
	// Channel, level, expected result
	row_t rows [8] = '{'{3'h0, 12'hFFB, 10'h000}, '{3'h1, 12'h000, 10'h000}, '{3'h2, 12'h001, 10'h001},
		'{3'h3, 12'h200, 10'h200}, '{3'h4, 12'h3FF, 10'h3FF}, '{3'h5, 12'h5DC, 10'h3FF},
		'{3'h6, 12'h2AA, 10'h2AA}, '{3'h7, 12'h155, 10'h155}};
	adc_conversion_ctrl dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.comparator_bit(cmp), .under_range(under), .over_range(over), .channel_onehot(onehot),
		.sample_active(sa), .hold_active(ha), .trial_code(trial), .reference_buffer(rb),
		.converter_power(pw), .irq(irq));
	adc_core_model u_core (.clk(clk), .levels(levels), .channel_onehot(onehot), .hold_active(ha),
		.trial_code(trial), .comparator_bit(cmp), .under_range(under), .over_range(over));
	// Free-running system clock
	initial begin
		forever #10 clk = ~clk;
	end
	// Verdict and end of run
	task automatic end_sim();
		if (failures == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim
	// Compare and count
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One APB transfer, held until pready; a is the word index, the bus gets four times it
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {a, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		q = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Poll the busy bit, bounded
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			apb(1'b0, 12'hF70, 8'h00);
			n++;
		end while (q[7] === 1'b1 && n < 300);
		chk({9'h000, q[7]}, 10'h000);
	endtask : wait_idle
	// Present a level on one channel and start it
	task automatic start(input logic [2:0] ch, input logic [11:0] lv);
		logic [95:0] l;
		l = {8{12'h0F0}};
		l[12*ch +: 12] = lv;
		levels <= l;
		apb(1'b1, 12'hF70, {2'b10, ch[0], 2'b10, ch});
	endtask : start
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		foreach (reg_a[i]) begin
			apb(1'b0, reg_a[i], 8'h00);
			chk({1'b0, e, q}, reg_v[i]);
		end
		apb(1'b1, 12'hF77, 8'h01);
		apb(1'b1, 12'hF71, 8'h02);
		apb(1'b1, 12'hF74, 8'h05);
		apb(1'b1, 12'hF70, 8'h10);
		apb(1'b0, 12'hF70, 8'h00);
		chk({2'b00, q}, 10'h010);
		foreach (rows[i]) begin
			start(rows[i].ch, rows[i].lv);
			@(negedge clk);
			chk({2'b00, onehot}, 10'h001 << rows[i].ch);
			chk({8'h00, pw, rb}, {9'h001, rows[i].ch[0]});
			wait_idle();
			chk({9'h000, irq}, 10'h001);
			apb(1'b0, 12'hF72, 8'h00);
			chk({2'b00, q}, {2'b00, rows[i].res[9:2]});
			apb(1'b0, 12'hF73, 8'h00);
			chk({2'b00, q}, {2'b00, rows[i].res[1:0], 6'h00});
			apb(1'b1, 12'hF76, 8'h01);
			@(negedge clk);
			chk({9'h000, irq}, 10'h000);
		end
		// Restart in mid-conversion; only the second may land
		start(3'h1, 12'h3C3);
		repeat (90) @(posedge clk);
		start(3'h2, 12'h0AB);
		wait_idle();
		apb(1'b0, 12'hF73, 8'h00);
		chk({2'b00, q}, 10'h040);
		apb(1'b0, 12'hF72, 8'h00);
		chk({2'b00, q}, 10'h02A);
		apb(1'b0, 12'hF73, 8'h00);
		chk({2'b00, q}, 10'h0C0);
		// Disable with a request pending
		apb(1'b1, 12'hF70, 8'h00);
		@(negedge clk);
		chk({8'h00, irq, pw}, 10'h002);
		// Start from disabled, then reset in mid-sampling: all returns to idle
		start(3'h3, 12'h100);
		repeat (20) @(posedge clk);
		chk({9'h000, sa}, 10'h001);
		rst <= 1'b1;
		@(negedge clk);
		chk({sa, ha, pw, rb, irq, 5'h00}, 10'h000);
		chk({2'b00, onehot}, 10'h000);
		chk(trial, 10'h000);
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, 12'hF70, 8'h00);
		chk({2'b00, q}, 10'h000);
		apb(1'b0, 12'hF76, 8'h00);
		chk({2'b00, q}, 10'h000);
		apb(1'b0, 12'hF71, 8'h00);
		chk({2'b00, q}, 10'h001);
		end_sim();
	end
	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		$display("Error at %0t: timeout", $time);
		end_sim();
	end
endmodule : testbench
`default_nettype wire
